// *** design/telegram_master_pkg.sv ***
package telegram_master_pkg;
    // Character framing.
    localparam int unsigned CHAR_BITS = 11;
    localparam int unsigned DATA_BITS = 8;
    localparam logic [7:0] START_MARKER = 8'h02;
    localparam logic [7:0] CHECK_INIT = 8'h00;
    // Address byte fields.
    localparam int unsigned ADDR_FORMAT_BIT = 7;
    localparam int unsigned ADDR_BCAST_BIT = 5;
    localparam logic [6:0] LONG_BCAST = 7'h00;
    // Length accounting: address plus check byte.
    localparam logic [7:0] LEN_OVERHEAD = 8'h02;
    localparam logic [7:0] TEXT_FIXED = 8'h0A;
    // Telegram profile value that selects this framing.
    localparam logic [1:0] PROFILE_THIS = 2'h1;
    // Timing.
    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned GAP_CHARS = 2;
    localparam int unsigned RESP_MAX_MS = 20;
    localparam longint unsigned RESP_MAX_CYCLES = longint'(CLK_HZ) / 1000 * RESP_MAX_MS;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned FIFO_WIDTH = 8;
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'hA;
    localparam logic [3:0] BIT_PARITY = 4'h9;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Short or long address format and broadcast decode.
    function automatic logic isBroadcast(input logic [7:0] addr);
        if (addr[ADDR_FORMAT_BIT]) begin
            return addr[6:0] == LONG_BCAST;
        end
        return addr[ADDR_BCAST_BIT];
    endfunction

    // Even parity over data and parity bit: parity equals XOR of data.
    function automatic logic evenParity(input logic [7:0] d);
        return ^d;
    endfunction
endpackage

// *** design/byte_fifo.sv ***
`timescale 1ns/10ps
module byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_reg, rdPtr_reg;
    logic [AW:0] wrPtr_next, rdPtr_next;
    logic doWrite, doRead;

    // Honest full and empty from pointer comparison.
    always_comb begin
        inReady = (wrPtr_reg[AW-1:0] != rdPtr_reg[AW-1:0]) || (wrPtr_reg[AW] == rdPtr_reg[AW]);
        outValid = wrPtr_reg != rdPtr_reg;
        outData = mem[rdPtr_reg[AW-1:0]];
        doWrite = inValid && inReady;
        doRead = outValid && outReady;
        wrPtr_next = wrPtr_reg + (AW+1)'(doWrite);
        rdPtr_next = rdPtr_reg + (AW+1)'(doRead);
    end

    // Pointer registers and storage.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (doWrite) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end
endmodule

// *** design/telegram_master.sv ***
`timescale 1ns/10ps
// How it works
// - Start, eight data, parity, stop: eleven bits.
// - Parity makes ones count even.
// - Start marker, length, address, data, check.
// - Length counts data, address and check.
// - Text telegram length is ten plus text; here length is always body plus two.
// - Bit rate set by configuration, matches slave.
// - Master idles two characters after response.
// - Character gap over two characters breaks telegram.
// - Bit7 clear: short format, address 1-31.
// - Short format bit5 marks broadcast.
// - Bit7 set: long format, address 1-126.
// - Long format zero address is broadcast.
// - Checksum cleared before start marker.
// - Checksum is XOR of all bytes.
module telegram_master
    import telegram_master_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] bitDivisor,
    input wire logic [1:0] telegramProfile,
    input wire logic [7:0] txAddr,
    input wire logic txStart,
    input wire logic [7:0] txByte,
    input wire logic txByteValid,
    output logic txByteReady,
    input wire logic txLast,
    output logic lineOut,
    output logic lineOutEn,
    input wire logic lineIn,
    output logic [7:0] rxByte,
    output logic rxByteValid,
    input wire logic rxByteReady,
    output logic busy,
    output logic respOk,
    output logic respErr,
    output logic respTimeout
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_PAUSE = 7'b0000010,
        S_TXHDR = 7'b0000100,
        S_TXDATA = 7'b0001000,
        S_TXCHK = 7'b0010000,
        S_WAITRSP = 7'b0100000,
        S_RXRSP = 7'b1000000
    } state_t;

    localparam int unsigned GAP_BITS = GAP_CHARS * CHAR_BITS;

    state_t state_reg, state_next;
    logic [15:0] divCnt_reg, divCnt_next;
    logic [3:0] txBit_reg, txBit_next;
    logic [10:0] txShift_reg, txShift_next;
    logic txActive_reg, txActive_next;
    logic [7:0] txSum_reg, txSum_next;
    logic [1:0] hdrIdx_reg, hdrIdx_next;
    logic [5:0] gapBits_reg, gapBits_next;
    logic [31:0] waitCnt_reg, waitCnt_next;
    logic [7:0] rxSum_reg, rxSum_next;
    logic [7:0] rxLen_reg, rxLen_next;
    logic [7:0] rxIdx_reg, rxIdx_next;
    logic rxErr_reg, rxErr_next;
    logic [7:0] addrHold_reg, addrHold_next;
    logic lineOut_reg, lineOut_next, lineOutEn_reg, lineOutEn_next;
    logic respOk_reg, respOk_next, respErr_reg, respErr_next, respTo_reg, respTo_next;
    logic tick;
    logic [7:0] lenByte;
    logic [7:0] hdrByte;
    logic busy_reg, busy_next, rxValid_reg, rxValid_next;
    logic [7:0] bodyLen_reg, bodyLen_next;
    // Receiver sampler.
    logic [15:0] rxDiv_reg, rxDiv_next;
    logic [3:0] rxBit_reg, rxBit_next;
    logic [9:0] rxShift_reg, rxShift_next;
    logic rxBusy_reg, rxBusy_next;
    logic rxDone, rxParErr;
    logic [7:0] rxData;
    // Outgoing body bytes pass through the FIFO.
    logic [7:0] fifoData;
    logic fifoValid, fifoReady;

    byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) bodyFifo (
        .core_clk(core_clk),
        .rst(rst),
        .inData(txByte),
        .inValid(txByteValid && state_reg == S_IDLE),
        .inReady(fifoReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(state_reg == S_TXDATA && !txActive_reg && bodyLen_reg != BYTE_ZERO)
    );

    assign tick = divCnt_reg == bitDivisor;
    assign lenByte = bodyLen_reg + LEN_OVERHEAD;
    assign hdrByte = hdrIdx_reg == 2'h0 ? START_MARKER : (hdrIdx_reg == 2'h1 ? lenByte : addrHold_reg);
    assign txByteReady = fifoReady && state_reg == S_IDLE;
    // The stop bit is never shifted in, so data and parity sit one place up.
    assign rxData = rxShift_reg[8:1];
    assign rxParErr = rxShift_reg[BIT_PARITY] != evenParity(rxData);
    assign rxDone = rxBusy_reg && rxBit_reg == BIT_LAST && rxDiv_reg == (bitDivisor >> 1);
    assign lineOut = lineOut_reg;
    assign lineOutEn = lineOutEn_reg;
    assign rxByte = rxData;
    assign rxByteValid = rxValid_reg;
    assign busy = busy_reg;
    assign respOk = respOk_reg;
    assign respErr = respErr_reg;
    assign respTimeout = respTo_reg;

    // Receiver: start bit found, data and parity sampled at mid-bit, done ahead of the stop bit.
    always_comb begin
        rxDiv_next = rxDiv_reg + 16'h0001;
        rxBit_next = rxBit_reg;
        rxShift_next = rxShift_reg;
        rxBusy_next = rxBusy_reg;
        if (!rxBusy_reg) begin
            rxDiv_next = 16'h0000;
            rxBit_next = BIT_ZERO;
            rxBusy_next = !lineIn && state_reg inside {S_WAITRSP, S_RXRSP};
        end else if (rxDiv_reg == (rxBit_reg == BIT_ZERO ? (bitDivisor >> 1) : bitDivisor)) begin
            rxDiv_next = 16'h0000;
            rxBit_next = rxBit_reg + 4'h1;
            if (rxBit_reg != BIT_ZERO) begin
                rxShift_next = {lineIn, rxShift_reg[9:1]};
            end
        end
        if (rxDone) begin
            rxBusy_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rxDiv_reg <= 16'h0000;
            rxBit_reg <= BIT_ZERO;
            rxShift_reg <= '0;
            rxBusy_reg <= 1'b0;
        end else begin
            rxDiv_reg <= rxDiv_next;
            rxBit_reg <= rxBit_next;
            rxShift_reg <= rxShift_next;
            rxBusy_reg <= rxBusy_next;
        end
    end

    // Telegram sequencer: send, then collect and check the answer.
    always_comb begin
        state_next = state_reg;
        divCnt_next = tick ? 16'h0000 : divCnt_reg + 16'h0001;
        txBit_next = txBit_reg;
        txShift_next = txShift_reg;
        txActive_next = txActive_reg;
        txSum_next = txSum_reg;
        hdrIdx_next = hdrIdx_reg;
        gapBits_next = gapBits_reg;
        waitCnt_next = waitCnt_reg + 32'h1;
        rxSum_next = rxSum_reg;
        rxLen_next = rxLen_reg;
        rxIdx_next = rxIdx_reg;
        rxErr_next = rxErr_reg;
        addrHold_next = addrHold_reg;
        bodyLen_next = bodyLen_reg;
        lineOut_next = lineOut_reg;
        lineOutEn_next = lineOutEn_reg;
        respOk_next = 1'b0;
        respErr_next = 1'b0;
        respTo_next = 1'b0;
        rxValid_next = 1'b0;
        // Bit shifter for one character, LSB first after start bit.
        if (txActive_reg && tick) begin
            lineOut_next = txShift_reg[0];
            txShift_next = {1'b1, txShift_reg[10:1]};
            txBit_next = txBit_reg + 4'h1;
            if (txBit_reg == BIT_LAST) begin
                txActive_next = 1'b0;
            end
        end
        unique case (state_reg)
            S_IDLE: begin
                lineOutEn_next = 1'b0;
                lineOut_next = 1'b1;
                if (txByteValid && fifoReady) begin
                    bodyLen_next = bodyLen_reg + 8'h01;
                end
                if (txStart && telegramProfile == PROFILE_THIS) begin
                    addrHold_next = txAddr;
                    state_next = S_PAUSE;
                    gapBits_next = 6'h00;
                end
            end
            S_PAUSE: begin
                // Line idle at least two characters before a new telegram.
                if (tick) begin
                    gapBits_next = gapBits_reg + 6'h01;
                end
                if (gapBits_reg == 6'(GAP_BITS)) begin
                    state_next = S_TXHDR;
                    hdrIdx_next = 2'h0;
                    txSum_next = CHECK_INIT;
                    lineOutEn_next = 1'b1;
                end
            end
            S_TXHDR: begin
                if (!txActive_reg) begin
                    txShift_next = {1'b1, evenParity(hdrByte), hdrByte, 1'b0};
                    txActive_next = 1'b1;
                    txBit_next = BIT_ZERO;
                    txSum_next = txSum_reg ^ hdrByte;
                    hdrIdx_next = hdrIdx_reg + 2'h1;
                    if (hdrIdx_reg == 2'h2) begin
                        state_next = S_TXDATA;
                    end
                end
            end
            S_TXDATA: begin
                if (!txActive_reg) begin
                    if (bodyLen_reg == BYTE_ZERO) begin
                        state_next = S_TXCHK;
                        // A cleared bit count tells the check state its character is still to go.
                        txBit_next = BIT_ZERO;
                    end else if (fifoValid) begin
                        txShift_next = {1'b1, evenParity(fifoData), fifoData, 1'b0};
                        txActive_next = 1'b1;
                        txBit_next = BIT_ZERO;
                        txSum_next = txSum_reg ^ fifoData;
                        bodyLen_next = bodyLen_reg - 8'h01;
                    end
                end
            end
            S_TXCHK: begin
                if (!txActive_reg && txBit_reg != BIT_LAST + 4'h1) begin
                    txShift_next = {1'b1, evenParity(txSum_reg), txSum_reg, 1'b0};
                    txActive_next = 1'b1;
                    txBit_next = BIT_ZERO;
                end else if (!txActive_reg) begin
                    lineOutEn_next = 1'b0;
                    waitCnt_next = 32'h0;
                    rxSum_next = CHECK_INIT;
                    rxIdx_next = BYTE_ZERO;
                    rxErr_next = 1'b0;
                    txBit_next = BIT_ZERO;
                    // No answer comes to a broadcast.
                    state_next = isBroadcast(addrHold_reg) ? S_IDLE : S_WAITRSP;
                end
            end
            S_WAITRSP, S_RXRSP: begin
                if (rxDone) begin
                    waitCnt_next = 32'h0;
                    state_next = S_RXRSP;
                    rxSum_next = rxSum_reg ^ rxData;
                    rxIdx_next = rxIdx_reg + 8'h01;
                    rxValid_next = 1'b1;
                    if (rxIdx_reg == 8'h01) begin
                        rxLen_next = rxData;
                    end
                    if (rxParErr || (rxIdx_reg == BYTE_ZERO && rxData != START_MARKER)
                        || (rxIdx_reg == 8'h02 && rxData != addrHold_reg)) begin
                        rxErr_next = 1'b1;
                    end
                    if (rxIdx_reg > 8'h01 && rxIdx_reg == rxLen_reg + 8'h01) begin
                        respOk_next = !rxErr_reg && (rxSum_reg ^ rxData) == BYTE_ZERO && !rxParErr;
                        respErr_next = rxErr_reg || (rxSum_reg ^ rxData) != BYTE_ZERO || rxParErr;
                        state_next = S_IDLE;
                    end
                end else if (state_reg == S_WAITRSP && waitCnt_reg == 32'(RESP_MAX_CYCLES)) begin
                    respTo_next = 1'b1;
                    state_next = S_IDLE;
                end else if (state_reg == S_RXRSP && !rxBusy_reg
                    && waitCnt_reg == 32'(GAP_BITS) * 32'(bitDivisor + 16'h1)) begin
                    respErr_next = 1'b1;
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
        busy_next = state_next != S_IDLE;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_IDLE;
            divCnt_reg <= 16'h0000;
            txBit_reg <= BIT_ZERO;
            txShift_reg <= '1;
            txActive_reg <= 1'b0;
            txSum_reg <= CHECK_INIT;
            hdrIdx_reg <= 2'h0;
            gapBits_reg <= 6'h00;
            waitCnt_reg <= 32'h0;
            rxSum_reg <= CHECK_INIT;
            rxLen_reg <= BYTE_ZERO;
            rxIdx_reg <= BYTE_ZERO;
            rxErr_reg <= 1'b0;
            addrHold_reg <= BYTE_ZERO;
            bodyLen_reg <= BYTE_ZERO;
            lineOut_reg <= 1'b1;
            lineOutEn_reg <= 1'b0;
            respOk_reg <= 1'b0;
            respErr_reg <= 1'b0;
            respTo_reg <= 1'b0;
            busy_reg <= 1'b0;
            rxValid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            divCnt_reg <= divCnt_next;
            txBit_reg <= txBit_next;
            txShift_reg <= txShift_next;
            txActive_reg <= txActive_next;
            txSum_reg <= txSum_next;
            hdrIdx_reg <= hdrIdx_next;
            gapBits_reg <= gapBits_next;
            waitCnt_reg <= waitCnt_next;
            rxSum_reg <= rxSum_next;
            rxLen_reg <= rxLen_next;
            rxIdx_reg <= rxIdx_next;
            rxErr_reg <= rxErr_next;
            addrHold_reg <= addrHold_next;
            bodyLen_reg <= bodyLen_next;
            lineOut_reg <= lineOut_next;
            lineOutEn_reg <= lineOutEn_next;
            respOk_reg <= respOk_next;
            respErr_reg <= respErr_next;
            respTo_reg <= respTo_next;
            busy_reg <= busy_next;
            rxValid_reg <= rxValid_next;
        end
    end

    // Checks on framing and turnaround.
    property p_pauseBeforeSend;
        @(posedge core_clk) disable iff (rst)
        $rose(lineOutEn) |-> $past(state_reg) == S_PAUSE;
    endproperty
    a_pauseBeforeSend: assert property (p_pauseBeforeSend) else $error("Drive began without pause.");

    property p_startChecksum;
        @(posedge core_clk) disable iff (rst)
        (state_reg == S_PAUSE && state_next == S_TXHDR) |=> txSum_reg == CHECK_INIT;
    endproperty
    a_startChecksum: assert property (p_startChecksum) else $error("Checksum not cleared.");

    property p_profileGate;
        @(posedge core_clk) disable iff (rst)
        (state_reg == S_IDLE && telegramProfile != PROFILE_THIS) |=> state_reg == S_IDLE;
    endproperty
    a_profileGate: assert property (p_profileGate) else $error("Sent under other profile.");

    property p_noBroadcastWait;
        @(posedge core_clk) disable iff (rst)
        (state_reg == S_TXCHK && isBroadcast(addrHold_reg)) |=> state_reg != S_WAITRSP;
    endproperty
    a_noBroadcastWait: assert property (p_noBroadcastWait) else $error("Waited on broadcast.");

    property p_idleLine;
        @(posedge core_clk) disable iff (rst)
        !lineOutEn |-> lineOut;
    endproperty
    a_idleLine: assert property (p_idleLine) else $error("Line low while released.");

    property p_checkGood;
        @(posedge core_clk) disable iff (rst)
        respOk |-> !respErr && !respTimeout;
    endproperty
    a_checkGood: assert property (p_checkGood) else $error("Conflicting results.");

    property p_headerParity;
        @(posedge core_clk) disable iff (rst)
        (state_reg == S_TXHDR && !txActive_reg) |=> ^txShift_reg[9:1] == 1'b0;
    endproperty
    a_headerParity: assert property (p_headerParity) else $error("Odd parity sent.");

    property p_timeoutBound;
        @(posedge core_clk) disable iff (rst)
        respTimeout |-> $past(state_reg) == S_WAITRSP;
    endproperty
    a_timeoutBound: assert property (p_timeoutBound) else $error("Timeout outside wait.");

    // The check character follows the body and carries the running sum.
    sequence s_checkEntered;
        state_reg == S_TXDATA ##1 state_reg == S_TXCHK;
    endsequence

    sequence s_checkLoaded;
        txActive_reg && txShift_reg[8:1] == txSum_reg;
    endsequence

    property p_checkByteSent;
        @(posedge core_clk) disable iff (rst)
        s_checkEntered |=> s_checkLoaded;
    endproperty
    a_checkByteSent: assert property (p_checkByteSent) else $error("Check byte not loaded.");
endmodule

// *** tb/slave_model.sv ***
`timescale 1ns/10ps
module slave_model
    import telegram_master_pkg::*;
#(
    parameter int BIT = 10,
    parameter logic [4:0] SHORT_ADDR = 5'h16,
    parameter logic [6:0] LONG_ADDR = 7'h55
) (
    input wire logic core_clk,
    input wire logic lineOut,
    input wire logic lineOutEn,
    input wire logic [2:0] fault,
    output logic lineIn
);
    logic busLine;
    logic txEn = 1'b0;
    logic txBit = 1'b1;
    int idleCnt = 0;
    int lastIdle = 0;
    int frames = 0;
    int gapSeen = 0;
    logic frameOk = 1'b0;
    logic [7:0] addrSeen = 8'h00;
    logic [7:0] lenSeen = 8'h00;
    logic [7:0] body [0:63];

    // The bus is biased high whenever nobody drives it.
    assign busLine = lineOutEn ? lineOut : 1'b1;
    assign lineIn = txEn ? txBit : 1'b1;

    // Counts quiet cycles on the bus so the master's pause can be judged.
    always @(posedge core_clk) begin
        if (busLine === 1'b1 && !txEn) begin
            idleCnt <= idleCnt + 1;
        end else begin
            idleCnt <= 0;
        end
    end

    // Samples one character at mid-bit and checks its framing.
    task automatic getChar(output logic [7:0] b, output logic ok);
        logic [10:0] f;
        do @(posedge core_clk); while (busLine !== 1'b0);
        lastIdle = idleCnt;
        repeat (BIT / 2) @(posedge core_clk);
        for (int i = 0; i < 11; i++) begin
            f[i] = busLine;
            if (i < 10) repeat (BIT) @(posedge core_clk);
        end
        b = f[8:1];
        ok = f[0] === 1'b0 && f[10] === 1'b1 && (^f[9:1]) === 1'b0;
    endtask

    // Sends one character, optionally with the parity bit turned round.
    task automatic putChar(input logic [7:0] b, input logic badPar);
        logic [10:0] f;
        f = {1'b1, (^b) ^ badPar, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            txBit <= f[i];
            repeat (BIT) @(posedge core_clk);
        end
    endtask

    // Takes in each telegram and answers only clean ones for this node.
    initial begin
        logic [7:0] b;
        logic [7:0] chk;
        logic [7:0] rsp [0:4];
        logic ok;
        logic good;
        forever begin
            getChar(b, ok);
            gapSeen = lastIdle;
            good = ok && b === START_MARKER;
            chk = CHECK_INIT ^ b;
            getChar(lenSeen, ok);
            good = good && ok;
            chk = chk ^ lenSeen;
            getChar(addrSeen, ok);
            good = good && ok;
            chk = chk ^ addrSeen;
            for (int i = 0; i + 2 < int'(lenSeen); i++) begin
                getChar(body[i], ok);
                good = good && ok;
                chk = chk ^ body[i];
            end
            getChar(b, ok);
            frameOk = good && ok && b === chk;
            frames++;
            if (frameOk && ((!addrSeen[7] && !addrSeen[5] && addrSeen[4:0] == SHORT_ADDR) ||
                (addrSeen[7] && addrSeen[6:0] == LONG_ADDR))) begin
                repeat (25 * BIT) @(posedge core_clk);
                rsp[0] = START_MARKER;
                rsp[1] = 8'h04;
                rsp[2] = fault == 3'h3 ? addrSeen ^ 8'h01 : addrSeen;
                rsp[3] = 8'hA5;
                rsp[4] = 8'h3C;
                chk = CHECK_INIT;
                txEn <= 1'b1;
                for (int i = 0; i < 5; i++) begin
                    putChar(rsp[i], fault == 3'h2 && i == 3);
                    chk = chk ^ rsp[i];
                    if (fault == 3'h4 && i == 2) repeat (30 * BIT) @(posedge core_clk);
                end
                putChar(fault == 3'h1 ? ~chk : chk, 1'b0);
                txEn <= 1'b0;
            end
        end
    end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
    import telegram_master_pkg::*;
    localparam int BIT = 10;
    localparam int LIMIT = 90000;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] bitDivisor = 16'(BIT - 1);
    logic [1:0] telegramProfile = PROFILE_THIS;
    logic [7:0] txAddr = 8'h00;
    logic txStart = 1'b0;
    logic [7:0] txByte = 8'h00;
    logic txByteValid = 1'b0;
    logic txByteReady;
    logic lineOut;
    logic lineOutEn;
    logic lineIn;
    logic busy;
    logic respOk;
    logic respErr;
    logic respTimeout;
    logic [7:0] rxByte;
    logic rxByteValid;
    logic [7:0] rxLast = 8'h00;
    int rxCnt = 0;
    logic [2:0] fault = 3'h0;
    int okCnt = 0;
    int errCnt = 0;
    int toCnt = 0;
    int cycles = 0;
    int nErrors = 0;
    int checksDone = 0;

    telegram_master telegram_master_i (.core_clk(core_clk), .rst(rst), .bitDivisor(bitDivisor),
        .telegramProfile(telegramProfile), .txAddr(txAddr), .txStart(txStart), .txByte(txByte),
        .txByteValid(txByteValid), .txByteReady(txByteReady), .txLast(1'b0), .lineOut(lineOut),
        .lineOutEn(lineOutEn), .lineIn(lineIn), .rxByte(rxByte), .rxByteValid(rxByteValid), .rxByteReady(1'b1),
        .busy(busy), .respOk(respOk), .respErr(respErr), .respTimeout(respTimeout));

    slave_model #(.BIT(BIT)) slave_model_i (.core_clk(core_clk), .lineOut(lineOut),
        .lineOutEn(lineOutEn), .fault(fault), .lineIn(lineIn));

    // Free-running clock.
    always #5 core_clk = ~core_clk;

    // Tallies outcome pulses and cuts a hang short.
    always @(posedge core_clk) begin
        okCnt <= okCnt + int'(respOk === 1'b1);
        errCnt <= errCnt + int'(respErr === 1'b1);
        toCnt <= toCnt + int'(respTimeout === 1'b1);
        rxCnt <= rxCnt + int'(rxByteValid === 1'b1);
        if (rxByteValid === 1'b1) rxLast <= rxByte;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            nErrors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("errors %0d, checks %0d", nErrors, checksDone);
        if (nErrors == 0 && checksDone > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Pushes the body through the FIFO handshake, holding valid between bytes.
    task automatic loadBody(input int n, input logic [7:0] base);
        int i;
        i = 0;
        while (i < n) begin
            txByte <= base + 8'(i);
            txByteValid <= 1'b1;
            @(negedge core_clk);
            if (txByteReady === 1'b1) i++;
            @(posedge core_clk);
        end
        txByteValid <= 1'b0;
    endtask

    // Sends one telegram and judges the frame on the wire and the outcome pulses.
    task automatic runCase(input logic [7:0] addr, input int n, input logic [2:0] flt, input int expOk,
        input int expErr);
        int f0;
        int ok0;
        int err0;
        int to0;
        int rx0;
        int k;
        @(posedge core_clk);
        f0 = slave_model_i.frames;
        ok0 = okCnt;
        err0 = errCnt;
        to0 = toCnt;
        rx0 = rxCnt;
        fault <= flt;
        loadBody(n, addr);
        if (n == FIFO_DEPTH) begin
            @(negedge core_clk);
            check(txByteReady, 1'b0);
            @(posedge core_clk);
        end
        txAddr <= addr;
        txStart <= 1'b1;
        @(posedge core_clk);
        txStart <= 1'b0;
        @(negedge core_clk);
        check(busy, 1'b1);
        k = 0;
        while (busy !== 1'b0 && k < 12000) begin
            @(negedge core_clk);
            k++;
        end
        check(k < 12000, 1'b1);
        while (slave_model_i.txEn === 1'b1) @(negedge core_clk);
        repeat (30 * BIT) @(negedge core_clk);
        check(slave_model_i.frames, f0 + 1);
        check(slave_model_i.frameOk, 1'b1);
        check(slave_model_i.lenSeen, n + 2);
        check(slave_model_i.addrSeen, addr);
        check(slave_model_i.gapSeen >= 22 * BIT, 1'b1);
        for (k = 0; k < n; k++) check(slave_model_i.body[k], addr + 8'(k));
        check(okCnt - ok0, expOk);
        check(errCnt - err0, expErr);
        check(toCnt - to0, 0);
        if (expOk == 1) begin
            check(rxCnt - rx0, 6);
            check(rxLast, START_MARKER ^ 8'h04 ^ addr ^ 8'hA5 ^ 8'h3C);
        end
    endtask

    // Start requests under every other profile value must be refused.
    task automatic refuseCase();
        int f0;
        f0 = slave_model_i.frames;
        for (int p = 0; p < 4; p++) begin
            @(posedge core_clk);
            telegramProfile <= 2'(p);
            txAddr <= 8'h16;
            txStart <= (p != 1);
            @(posedge core_clk);
            txStart <= 1'b0;
            @(negedge core_clk);
            if (p != 1) check(busy, 1'b0);
        end
        repeat (50) @(posedge core_clk);
        telegramProfile <= PROFILE_THIS;
        check(slave_model_i.frames, f0);
    endtask

    // Main sequence: reset, addressed, broadcast, faulty replies, refusal, full FIFO.
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        runCase(8'h16, 4, 3'h0, 1, 0);
        runCase(8'h56, 12, 3'h0, 1, 0);
        runCase(8'hD5, 11, 3'h0, 1, 0);
        runCase(8'h3F, 2, 3'h0, 0, 0);
        runCase(8'h80, 3, 3'h0, 0, 0);
        for (int f = 1; f < 5; f++) runCase(8'h16, 2, 3'(f), 0, 1);
        refuseCase();
        runCase(8'h16, FIFO_DEPTH, 3'h0, 1, 0);
        end_sim();
    end
endmodule
